// ### inc/spoc_cfg.svh
// offsets, field positions, reset values and timing counts for pin control
`ifndef SPOC_CFG_SVH
`define SPOC_CFG_SVH
`define SPOC_ADDR_W        20
`define SPOC_OFS_FILTER    20'hF0070
`define SPOC_OFS_HELD_DATA 20'hF0128
`define SPOC_OFS_HELD_CLK  20'hF0129
`define SPOC_OFS_ENG_EN    20'hF012A
`define SPOC_OFS_INVERT    20'hF0134
`define SPOC_OFS_RUN_CTRL  20'hF0140
`define SPOC_BIT_CH0       0
`define SPOC_BIT_FIXED     1
`define SPOC_BIT_START     0
`define SPOC_BIT_STOP      1
`define SPOC_RST_FILTER    8'h00
`define SPOC_RST_HELD_DATA 8'h03
`define SPOC_RST_HELD_CLK  8'h03
`define SPOC_RST_ENG_EN    8'h00
`define SPOC_RST_INVERT    8'h00
`define SPOC_FILTER_SAMPLES 2
`endif

// ### inc/spoc_pkg.sv
// types shared by the pin output control block
package spoc_pkg;
    typedef logic [19:0] spoc_addr_t;
    typedef logic [7:0]  spoc_data_t;
endpackage

// ### hw/spoc_pin_ctrl.sv
// pin output control and receive filter for serial channel zero
`timescale 1ns/100ps
`include "spoc_cfg.svh"

// Behaviour
// [RULE_01] engine enable 1: pin driven by engine, held data writes blocked
// [RULE_02] engine enable 0: pin driven by software held data level
// [RULE_03] engine enable bit: 0 disabled, 1 enabled from serial engine
// [RULE_04] engine enable register resets to 00H, only bit 0 exists
// [RULE_05] held data bit writable only while engine enable is 0
// [RULE_06] held data register resets to 03H, bit 1 fixed one
// [RULE_07] software sets held data bit to one before port use
// [RULE_08] held clock bit writable only while channel run status is 0
// [RULE_09] held clock register resets to 03H, clock pin shows its bit; code shows it only while run status is 0, eng_clk_out while running
// [RULE_10] software sets held clock bit to one before port use
// [RULE_11] inversion bit 0 passes, 1 inverts transmit data in UART
// [RULE_12] inversion acts only while engine enable is 1
// [RULE_13] software leaves inversion register alone while channel runs
// [RULE_14] software keeps inversion zero in clocked serial mode
// [RULE_15] inversion register resets to 00H, only bit 0 exists
// [RULE_16] filter on: synchronise, accept level stable two cycles
// [RULE_17] filter off: only synchronise the receive input
// [RULE_18] software sets filter per pin use, off CSI, on UART
// [RULE_19] filter register resets to 00H, bit 0 one means on
// [RULE_20] start trigger sets run status, stop trigger clears it
// [RULE_21] filtered receive holds until two synced samples agree
module spoc_pin_ctrl (
    input  wire logic             clk_sys,        // system clock 250 MHz
    input  wire logic             rstn,           // sync reset, active low
    input  wire spoc_pkg::spoc_addr_t reg_addr,   // register address
    input  wire spoc_pkg::spoc_data_t reg_wdata,  // write data
    input  wire logic             reg_wr,         // write strobe
    input  wire logic             reg_rd,         // read strobe
    output spoc_pkg::spoc_data_t  reg_rdata,      // read data, next cycle
    input  wire logic             eng_data_out,   // engine transmit bit
    input  wire logic             eng_data_upd,   // engine updates held data
    input  wire logic             eng_clk_out,    // engine clock level
    input  wire logic             eng_clk_upd,    // engine updates held clk
    input  wire logic             uart_receive_pin, // raw receive pin
    output logic                  data_out_pin,   // serial data pin
    output logic                  clock_out_pin,  // serial clock pin
    output logic                  rx_filtered,    // conditioned receive
    output logic                  channel_run_status // channel enabled
);
    import spoc_pkg::*;

    logic eng_en_r;
    logic held_data_r;
    logic held_clk_r;
    logic invert_r;
    logic filter_r;
    logic run_r;
    logic rx_s1_r;
    logic rx_s2_r;
    logic rx_s3_r;
    logic rx_out_r;
    logic data_pin_r;
    logic clk_pin_r;
    spoc_data_t rdata_r;
    logic data_pin_nxt;

    // write hit decode
    function automatic logic hit(input spoc_addr_t a, input spoc_addr_t o);
        hit = (a == o);
    endfunction

    // engine enable register
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            eng_en_r <= 1'(`SPOC_RST_ENG_EN & 8'h01); // see [RULE_04]
        end else if (reg_wr && hit(reg_addr, `SPOC_OFS_ENG_EN)) begin
            eng_en_r <= reg_wdata[`SPOC_BIT_CH0]; // see [RULE_03]
        end
    end

    // held data level, software or engine owns it
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            held_data_r <= 1'(`SPOC_RST_HELD_DATA & 8'h01); // see [RULE_06]
        end else if (eng_en_r) begin
            if (eng_data_upd) begin
                held_data_r <= eng_data_out; // see [RULE_05]
            end
        end else if (reg_wr && hit(reg_addr, `SPOC_OFS_HELD_DATA)) begin
            held_data_r <= reg_wdata[`SPOC_BIT_CH0]; // see [RULE_05]
        end
    end

    // held clock level, software locked out while the channel runs, engine updates it
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            held_clk_r <= 1'(`SPOC_RST_HELD_CLK & 8'h01); // see [RULE_09]
        end else if (run_r) begin
            if (eng_clk_upd) begin
                held_clk_r <= eng_clk_out; // see [RULE_08]
            end
        end else if (reg_wr && hit(reg_addr, `SPOC_OFS_HELD_CLK)) begin
            held_clk_r <= reg_wdata[`SPOC_BIT_CH0]; // see [RULE_08]
        end
    end

    // inversion and filter enables
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            invert_r <= 1'(`SPOC_RST_INVERT & 8'h01); // see [RULE_15]
            filter_r <= 1'(`SPOC_RST_FILTER & 8'h01); // see [RULE_19]
        end else if (reg_wr) begin
            if (hit(reg_addr, `SPOC_OFS_INVERT)) begin
                invert_r <= reg_wdata[`SPOC_BIT_CH0];
            end
            if (hit(reg_addr, `SPOC_OFS_FILTER)) begin
                filter_r <= reg_wdata[`SPOC_BIT_CH0];
            end
        end
    end

    // run status from start and stop triggers, stop wins
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            run_r <= 1'b0;
        end else if (reg_wr && hit(reg_addr, `SPOC_OFS_RUN_CTRL)) begin
            if (reg_wdata[`SPOC_BIT_STOP]) begin
                run_r <= 1'b0; // see [RULE_20]
            end else if (reg_wdata[`SPOC_BIT_START]) begin
                run_r <= 1'b1; // see [RULE_20]
            end
        end
    end

    // data pin selection and inversion
    always_comb begin
        if (eng_en_r) begin
            data_pin_nxt = eng_data_out ^ invert_r; // see [RULE_01] [RULE_11]
        end else begin
            data_pin_nxt = held_data_r; // see [RULE_02] [RULE_12]
        end
    end

    // pin flops
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            data_pin_r <= 1'b1;
            clk_pin_r  <= 1'b1;
        end else begin
            data_pin_r <= data_pin_nxt;
            clk_pin_r  <= run_r ? eng_clk_out : held_clk_r; // see [RULE_09]
        end
    end

    // receive synchroniser and two-sample filter
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rx_s1_r  <= 1'b1;
            rx_s2_r  <= 1'b1;
            rx_s3_r  <= 1'b1;
            rx_out_r <= 1'b1;
        end else begin
            rx_s1_r <= uart_receive_pin;
            rx_s2_r <= rx_s1_r;
            rx_s3_r <= rx_s2_r;
            if (!filter_r) begin
                rx_out_r <= rx_s2_r; // see [RULE_17]
            end else if (rx_s2_r == rx_s3_r) begin
                rx_out_r <= rx_s2_r; // see [RULE_16] [RULE_21]
            end
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            unique case (1'b1)
                hit(reg_addr, `SPOC_OFS_ENG_EN):
                    rdata_r <= {7'h00, eng_en_r};
                hit(reg_addr, `SPOC_OFS_HELD_DATA):
                    rdata_r <= {6'h00, 1'b1, held_data_r};
                hit(reg_addr, `SPOC_OFS_HELD_CLK):
                    rdata_r <= {6'h00, 1'b1, held_clk_r};
                hit(reg_addr, `SPOC_OFS_INVERT):
                    rdata_r <= {7'h00, invert_r};
                hit(reg_addr, `SPOC_OFS_FILTER):
                    rdata_r <= {7'h00, filter_r};
                hit(reg_addr, `SPOC_OFS_RUN_CTRL):
                    rdata_r <= {7'h00, run_r};
                default:
                    rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata          = rdata_r;
    assign data_out_pin       = data_pin_r;
    assign clock_out_pin      = clk_pin_r;
    assign rx_filtered        = rx_out_r;
    assign channel_run_status = run_r;

    // software write to the held data register
    sequence s_sw_held_write;
        reg_wr && hit(reg_addr, `SPOC_OFS_HELD_DATA);
    endsequence

    // software write to the held clock register
    sequence s_sw_clk_write;
        reg_wr && hit(reg_addr, `SPOC_OFS_HELD_CLK);
    endsequence

    // stop trigger written, alone or beside start
    sequence s_stop_trigger;
        reg_wr && hit(reg_addr, `SPOC_OFS_RUN_CTRL) && reg_wdata[1];
    endsequence

    // software cannot move held data while engine owns it
    a_held_data_locked: assert property ( // see [RULE_05]
        @(posedge clk_sys) disable iff (!rstn)
        s_sw_held_write and eng_en_r && !eng_data_upd
        |=> held_data_r == $past(held_data_r))
        else $error("held data changed by software while engine enabled");

    // software write lands while engine disabled
    a_held_data_write: assert property ( // see [RULE_05]
        @(posedge clk_sys) disable iff (!rstn)
        s_sw_held_write and !eng_en_r
        |=> held_data_r == $past(reg_wdata[0]))
        else $error("held data write lost while engine disabled");

    // engine bit, possibly inverted, reaches the pin
    a_engine_drives_pin: assert property ( // see [RULE_01]
        @(posedge clk_sys) disable iff (!rstn)
        eng_en_r |=> data_out_pin == ($past(eng_data_out) ^ $past(invert_r)))
        else $error("data pin not following engine");

    // held level reaches the pin without inversion
    a_held_drives_pin: assert property ( // see [RULE_12]
        @(posedge clk_sys) disable iff (!rstn)
        !eng_en_r |=> data_out_pin == $past(held_data_r))
        else $error("data pin not showing held level");

    // held clock frozen for software while running
    a_held_clk_locked: assert property ( // see [RULE_08]
        @(posedge clk_sys) disable iff (!rstn)
        run_r && !eng_clk_upd |=> held_clk_r == $past(held_clk_r))
        else $error("held clock changed while channel runs");

    // stopped channel shows the held clock level
    a_clk_pin_held: assert property ( // see [RULE_09]
        @(posedge clk_sys) disable iff (!rstn)
        !run_r |=> clock_out_pin == $past(held_clk_r))
        else $error("clock pin not showing held level");

    // disagreeing samples leave the filter output alone
    a_filter_stable: assert property ( // see [RULE_16]
        @(posedge clk_sys) disable iff (!rstn)
        filter_r && rx_s2_r != rx_s3_r |=> rx_filtered == $past(rx_filtered))
        else $error("filtered receive moved on unstable samples");

    // filter off gives the plain synchronised input
    a_filter_bypass: assert property ( // see [RULE_17]
        @(posedge clk_sys) disable iff (!rstn)
        !filter_r |=> rx_filtered == $past(uart_receive_pin, 3))
        else $error("unfiltered receive not two-flop synchronised");

    // start trigger alone sets the run status
    a_run_start: assert property ( // see [RULE_20]
        @(posedge clk_sys) disable iff (!rstn)
        reg_wr && hit(reg_addr, `SPOC_OFS_RUN_CTRL) && reg_wdata[0]
        && !reg_wdata[1] |=> channel_run_status)
        else $error("start trigger did not set run status");

    // stop trigger clears the run status, even beside start
    a_run_stop: assert property ( // see [RULE_20]
        @(posedge clk_sys) disable iff (!rstn)
        s_stop_trigger |=> !channel_run_status)
        else $error("stop trigger did not clear run status");

    // software write lands while channel stopped
    a_held_clk_write: assert property ( // see [RULE_08]
        @(posedge clk_sys) disable iff (!rstn)
        s_sw_clk_write and !run_r
        |=> held_clk_r == $past(reg_wdata[0]))
        else $error("held clock write lost while channel stopped");

    // engine owns the clock pin while running
    a_clk_pin_engine: assert property ( // see [RULE_08]
        @(posedge clk_sys) disable iff (!rstn)
        run_r |=> clock_out_pin == $past(eng_clk_out))
        else $error("clock pin not following engine");

    // agreeing samples are taken by the filter
    a_filter_accept: assert property ( // see [RULE_21]
        @(posedge clk_sys) disable iff (!rstn)
        filter_r && rx_s2_r == rx_s3_r
        |=> rx_filtered == $past(rx_s2_r))
        else $error("filtered receive ignored agreeing samples");

    // held data read shows bit 1 fixed at one
    a_held_data_rd: assert property ( // see [RULE_06]
        @(posedge clk_sys) disable iff (!rstn)
        reg_rd && hit(reg_addr, `SPOC_OFS_HELD_DATA)
        |=> reg_rdata == {6'h00, 1'b1, $past(held_data_r)})
        else $error("held data read value wrong");

    // engine enable reads back only its low bit
    a_eng_en_rd: assert property ( // see [RULE_04]
        @(posedge clk_sys) disable iff (!rstn)
        reg_rd && hit(reg_addr, `SPOC_OFS_ENG_EN)
        |=> reg_rdata == {7'h00, $past(eng_en_r)})
        else $error("engine enable read value wrong");
endmodule

// ### verification/spoc_peer.sv
// remote serial peer model driving the receive line
`timescale 1ns/100ps
module spoc_peer (
    input  wire logic level,   // commanded line level
    input  wire logic glitch,  // one-cycle noise request
    output logic      rx_line  // receive line toward device
);
    // line follows the level, noise flips it for one cycle
    assign rx_line = level ^ glitch;
endmodule

// ### verification/spoc_pin_ctrl_bench.sv
// self-checking bench for the pin output control block
`timescale 1ns/100ps
`include "spoc_cfg.svh"
module spoc_pin_ctrl_bench;
    import spoc_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rstn = 1'b0;
    spoc_addr_t reg_addr = '0;
    spoc_data_t reg_wdata = '0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       eng_data_out = 1'b0;
    logic       eng_data_upd = 1'b0;
    logic       eng_clk_out = 1'b1;
    logic       eng_clk_upd = 1'b0;
    logic       rx_level = 1'b1;
    logic       rx_glitch = 1'b0;
    spoc_data_t reg_rdata;
    logic       rx_pin, dout, cout, rx_filt, run;
    logic [7:0] pins;
    int         err_total = 0;
    int         compares = 0;
    spoc_addr_t ofs [5] = '{`SPOC_OFS_FILTER, `SPOC_OFS_HELD_DATA,
        `SPOC_OFS_HELD_CLK, `SPOC_OFS_ENG_EN, `SPOC_OFS_INVERT};
    spoc_data_t rstv [5] = '{8'h00, 8'h03, 8'h03, 8'h00, 8'h00};

    // pins packed as data, clock, receive, run
    assign pins = {4'h0, dout, cout, rx_filt, run};
    always #2 clk_sys = ~clk_sys;

    spoc_peer u_peer (.level(rx_level), .glitch(rx_glitch), .rx_line(rx_pin));
    spoc_pin_ctrl u_dut (
        .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .eng_data_out(eng_data_out),
        .eng_data_upd(eng_data_upd), .eng_clk_out(eng_clk_out),
        .eng_clk_upd(eng_clk_upd), .uart_receive_pin(rx_pin),
        .data_out_pin(dout), .clock_out_pin(cout), .rx_filtered(rx_filt),
        .channel_run_status(run));

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input spoc_data_t got, input spoc_data_t exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input spoc_addr_t a, input spoc_data_t d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input spoc_addr_t a, input spoc_data_t exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic pin_chk(input spoc_data_t exp);
        repeat (2) @(posedge clk_sys);
        #1 chk(pins, exp);
    endtask
    // drive receive level, count edges until the filtered output moves
    task automatic rx_step(input logic v, input int exp);
        int n;
        n = 0;
        @(posedge clk_sys);
        rx_level <= v;
        while (rx_filt !== v && n < 8) begin
            @(posedge clk_sys);
            #1 n++;
        end
        if (n == 8) begin
            err_total++;
            print_verdict();
        end
        chk(8'(n), 8'(exp));
    endtask
    // reads every register except run control, and the pins, against reset values
    task automatic rst_chk;
        for (int i = 0; i < 5; i++) begin
            rd(ofs[i], rstv[i]);
        end
        pin_chk(8'h0E);
    endtask

    // watchdog against a hung run
    initial begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        print_verdict();
    end

    // main sequence; inversion only written while the channel is stopped
    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        rst_chk();
        rd(20'hF0000, 8'h00);
        $display("test reset done");
        wr(`SPOC_OFS_HELD_DATA, 8'h00);
        pin_chk(8'h06);
        rd(`SPOC_OFS_HELD_DATA, 8'h02);
        wr(`SPOC_OFS_INVERT, 8'h01);
        pin_chk(8'h06);
        wr(`SPOC_OFS_ENG_EN, 8'h01);
        pin_chk(8'h0E);
        wr(`SPOC_OFS_HELD_DATA, 8'h01);
        rd(`SPOC_OFS_HELD_DATA, 8'h02);
        wr(`SPOC_OFS_INVERT, 8'h00);
        pin_chk(8'h06);
        @(posedge clk_sys);
        eng_data_out <= 1'b1;
        eng_data_upd <= 1'b1;
        @(posedge clk_sys);
        eng_data_upd <= 1'b0;
        eng_data_out <= 1'b0;
        rd(`SPOC_OFS_HELD_DATA, 8'h03);
        wr(`SPOC_OFS_ENG_EN, 8'h00);
        pin_chk(8'h0E);
        rd(`SPOC_OFS_ENG_EN, 8'h00);
        $display("test data pin done");
        wr(`SPOC_OFS_HELD_CLK, 8'h00);
        pin_chk(8'h0A);
        wr(`SPOC_OFS_RUN_CTRL, 8'h01);
        pin_chk(8'h0F);
        wr(`SPOC_OFS_HELD_CLK, 8'h01);
        rd(`SPOC_OFS_HELD_CLK, 8'h02);
        @(posedge clk_sys);
        eng_clk_upd <= 1'b1;
        @(posedge clk_sys);
        eng_clk_upd <= 1'b0;
        rd(`SPOC_OFS_HELD_CLK, 8'h03);
        wr(`SPOC_OFS_RUN_CTRL, 8'h02);
        wr(`SPOC_OFS_HELD_CLK, 8'h00);
        pin_chk(8'h0A);
        wr(`SPOC_OFS_HELD_CLK, 8'h01);
        wr(`SPOC_OFS_HELD_DATA, 8'h01);
        pin_chk(8'h0E);
        $display("test clock pin done");
        rx_step(1'b0, 3);
        wr(`SPOC_OFS_FILTER, 8'h01);
        rd(`SPOC_OFS_FILTER, 8'h01);
        rx_step(1'b1, 4);
        @(posedge clk_sys);
        rx_glitch <= 1'b1;
        @(posedge clk_sys);
        rx_glitch <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_sys);
            #1 chk(pins, 8'h0E);
        end
        $display("test receive filter done");
        // both triggers at once: stop wins
        wr(`SPOC_OFS_RUN_CTRL, 8'h01);
        rd(`SPOC_OFS_RUN_CTRL, 8'h01);
        wr(`SPOC_OFS_RUN_CTRL, 8'h03);
        rd(`SPOC_OFS_RUN_CTRL, 8'h00);
        // move every register off its reset value, then reset mid-run
        wr(`SPOC_OFS_HELD_DATA, 8'h00);
        wr(`SPOC_OFS_HELD_CLK, 8'h00);
        wr(`SPOC_OFS_INVERT, 8'h01);
        wr(`SPOC_OFS_ENG_EN, 8'h01);
        pin_chk(8'h0A);
        wr(`SPOC_OFS_RUN_CTRL, 8'h01);
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        rst_chk();
        rd(`SPOC_OFS_RUN_CTRL, 8'h00);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
